// ### cfg_loader.sv
/*
 Asynchronous peripheral configuration loader top: byte write port with
 ready/busy handshake, double-buffered parallel-to-serial converter, config clock.
 Assumes host pins synchronous to i_clk_sys; downstream memory takes a bit per enable.
*/
`timescale 1ns/10ps
`default_nettype none
module cfg_loader
	import cfg_loader_pkg::*;
(
	input  wire logic              i_clk_sys,
	input  wire logic              i_rstn,
	input  wire logic              i_chip_select_low_n,
	input  wire logic              i_chip_select_high,
	input  wire logic              i_write_strobe_n,
	input  wire logic              i_read_strobe_n,
	input  wire logic [BYTE_W-1:0] i_data,
	input  wire logic              i_init_all,
	input  wire logic              i_master_mode,
	input  wire logic              i_fast_rate,
	input  wire logic              i_ext_config_clock,
	output logic                   o_ready,
	output logic                   o_config_clock,
	output logic                   o_cfg_bit,
	output logic                   o_cfg_bit_valid
);

	// ----------------------------------------------------------------
	// Reset release
	// ----------------------------------------------------------------
	logic rst_meta;
	logic rst_n;
	always_ff @(posedge i_clk_sys or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end
		else
		begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	// ----------------------------------------------------------------
	// Config clock: internal divider or external pin edge
	// ----------------------------------------------------------------
	logic gen_clk;
	logic gen_rise;
	logic ext_prev;
	logic run;
	logic shift_en;

	// Loading is held off until every chained init is high
	assign run = i_init_all;

	cfg_clk_gen u_clk_gen (
		.i_clk_sys (i_clk_sys),
		.i_rst_n   (rst_n),
		.i_run     (run && i_master_mode),
		.i_fast    (i_fast_rate),
		.o_cfg_clk (gen_clk),
		.o_rise_en (gen_rise)
	);

	// External clock edge detect (pins synchronous by assumption)
	always_ff @(posedge i_clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			ext_prev <= 1'b0;
		else
			ext_prev <= i_ext_config_clock;
	end

	// Edge source follows mode; external party keeps period and delay
	assign shift_en = run && (i_master_mode ? gen_rise : (i_ext_config_clock && !ext_prev));

	// ----------------------------------------------------------------
	// Write port and converter state
	// ----------------------------------------------------------------
	wr_state_t         wr_state;
	wr_state_t         next_wr_state;
	logic [BYTE_W-1:0] in_reg;
	logic [BYTE_W-1:0] next_in_reg;
	logic              in_full;
	logic              next_in_full;
	logic [BYTE_W-1:0] shift_reg;
	logic [BYTE_W-1:0] next_shift_reg;
	logic              shift_full;
	logic              next_shift_full;
	logic [2:0]        bit_cnt;
	logic [2:0]        next_bit_cnt;
	logic              next_ready;
	logic              next_cfg_bit;
	logic              next_cfg_bit_valid;
	logic              wr_sel;
	logic              accept;
	logic [1:0]        stall_cnt;
	logic [1:0]        next_stall_cnt;

	// Effective write: low select and strobe low, read high, high select high
	assign wr_sel = !i_chip_select_low_n && i_chip_select_high && i_read_strobe_n && !i_write_strobe_n;

	// Converter, handshake and capture next state
	always_comb
	begin
		next_wr_state      = wr_state;
		next_in_reg        = in_reg;
		next_in_full       = in_full;
		next_shift_reg     = shift_reg;
		next_shift_full    = shift_full;
		next_bit_cnt       = bit_cnt;
		next_stall_cnt     = stall_cnt;
		next_cfg_bit       = o_cfg_bit;
		next_cfg_bit_valid = 1'b0;
		accept             = 1'b0;
		case (wr_state)
			WR_IDLE:
			begin
				if (wr_sel && o_ready)
				begin
					next_wr_state = WR_STROBE;
					next_in_reg   = i_data;
				end
			end
			WR_STROBE:
			begin
				// Latch only while strobe is low; data after the rising edge is ignored
				if (wr_sel)
					next_in_reg = i_data;
				else
				begin
					accept         = 1'b1;
					next_in_full   = 1'b1;
					next_stall_cnt = 2'h0;
					next_wr_state  = WR_BUSY;
				end
			end
			WR_BUSY:
			begin
				// Count config edges so the stall spans the minimum time
				if (shift_en && stall_cnt != STALL_MIN_EDGES)
					next_stall_cnt = stall_cnt + 2'h1;
				if (!in_full && stall_cnt == STALL_MIN_EDGES)
					next_wr_state = WR_IDLE;
			end
			default:
			begin
				next_wr_state = WR_IDLE;
			end
		endcase

		// Shift one bit per config clock edge; reload second stage when empty
		if (shift_en)
		begin
			if (shift_full)
			begin
				next_cfg_bit       = shift_reg[BYTE_W-1];
				next_cfg_bit_valid = 1'b1;
				next_shift_reg     = {shift_reg[BYTE_W-2:0], 1'b0};
				next_bit_cnt       = bit_cnt + 3'h1;
				if (bit_cnt == BIT_LAST)
					next_shift_full = 1'b0;
			end
			else if (in_full)
			begin
				// Transfer on a config edge: delay tracks prior byte and clock phase
				next_shift_reg  = in_reg;
				next_shift_full = 1'b1;
				next_bit_cnt    = 3'h0;
				next_in_full    = accept;
			end
		end

		// Ready low while input register still holds an untransferred byte
		next_ready = (next_wr_state != WR_BUSY) && !next_in_full;
	end

	// Converter and handshake registers
	always_ff @(posedge i_clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_state        <= WR_IDLE;
			in_reg          <= BYTE_RST;
			in_full         <= 1'b0;
			shift_reg       <= BYTE_RST;
			shift_full      <= 1'b0;
			bit_cnt         <= 3'h0;
			stall_cnt       <= 2'h0;
			o_ready         <= 1'b0;
			o_cfg_bit       <= 1'b0;
			o_cfg_bit_valid <= 1'b0;
			o_config_clock  <= 1'b0;
		end
		else
		begin
			wr_state        <= next_wr_state;
			in_reg          <= next_in_reg;
			in_full         <= next_in_full;
			shift_reg       <= next_shift_reg;
			shift_full      <= next_shift_full;
			bit_cnt         <= next_bit_cnt;
			stall_cnt       <= next_stall_cnt;
			o_ready         <= next_ready;
			o_cfg_bit       <= next_cfg_bit;
			o_cfg_bit_valid <= next_cfg_bit_valid;
			o_config_clock  <= i_master_mode ? gen_clk : i_ext_config_clock;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	logic [4:0] busy_edges;
	always_ff @(posedge i_clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			busy_edges <= 5'h00;
		else if (o_ready)
			busy_edges <= 5'h00;
		else if (shift_en && busy_edges != 5'h1F)
			busy_edges <= busy_edges + 5'h01;
	end

	busy_rise_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
		accept |-> ##[1:12] !o_ready)
		else $error("busy not shown after strobe end");

	busy_span_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
		(!o_ready && wr_state == WR_BUSY) |-> busy_edges <= 5'h09)
		else $error("stall longer than nine config clocks");

	busy_min_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
		($rose(o_ready) && $past(wr_state) == WR_BUSY) |-> $past(busy_edges) >= {3'h0, STALL_MIN_EDGES})
		else $error("stall shorter than allowed");

	capture_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
		(wr_state == WR_STROBE && wr_sel) |=> in_reg == $past(i_data))
		else $error("byte not captured during strobe");

	init_hold_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
		!i_init_all |=> !o_cfg_bit_valid)
		else $error("loading while init low");

	reload_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
		(shift_en && !shift_full && in_full) |=> shift_full && shift_reg == $past(in_reg))
		else $error("second stage failed to reload");

	shift_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
		(shift_en && shift_full) |=> o_cfg_bit_valid && o_cfg_bit == $past(shift_reg[BYTE_W-1]))
		else $error("bit not shifted out");

	long_stall_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
		(in_full && shift_full) |=> !o_ready)
		else $error("refill before shift should stall");

endmodule
`default_nettype wire

// ### cfg_loader_pkg.sv
/*
 Constants, types and timing figures for the asynchronous peripheral configuration loader.
 Assumes a single 200 MHz system clock; all times convert to cycles of that clock.
*/
`default_nettype none
package cfg_loader_pkg;

	// ----------------------------------------------------------------
	// Clock and timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_PS       = 5000;
	localparam int BUSY_DELAY_MAX_NS   = 60;
	localparam int BUSY_DELAY_CYC      = (BUSY_DELAY_MAX_NS * 1000) / CLK_PERIOD_PS;
	localparam int SLOW_PERIOD_MIN_NS  = 640;
	localparam int SLOW_PERIOD_MAX_NS  = 2000;
	localparam int FAST_PERIOD_MIN_NS  = 80;
	localparam int FAST_PERIOD_MAX_NS  = 250;
	// Chosen period is the least figure rounded up to whole system cycles
	localparam int SLOW_DIV_CYC        = (SLOW_PERIOD_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int FAST_DIV_CYC        = (FAST_PERIOD_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int DIV_W               = 8;
	localparam logic [DIV_W-1:0] SLOW_HALF = DIV_W'(SLOW_DIV_CYC / 2 - 1);
	localparam logic [DIV_W-1:0] FAST_HALF = DIV_W'(FAST_DIV_CYC / 2 - 1);

	// ----------------------------------------------------------------
	// Data path
	// ----------------------------------------------------------------
	localparam int BYTE_W              = 8;
	localparam logic [2:0] BIT_LAST    = 3'h7;
	localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;
	// Config edges counted in a stall; three edges span at least two full periods
	localparam logic [1:0] STALL_MIN_EDGES = 2'h3;

	// Write port handshake states
	typedef enum logic [1:0] {
		WR_IDLE,
		WR_STROBE,
		WR_BUSY
	} wr_state_t;

endpackage
`default_nettype wire

// ### cfg_clk_gen.sv
/*
 Configuration clock generator: divides the system clock into a config clock pin
 and a one-cycle enable at each rising edge of it.
 Assumes synchronous reset copy from the top and a stable rate select.
*/
`timescale 1ns/10ps
`default_nettype none
module cfg_clk_gen
	import cfg_loader_pkg::*;
(
	input  wire logic i_clk_sys,
	input  wire logic i_rst_n,
	input  wire logic i_run,
	input  wire logic i_fast,
	output logic      o_cfg_clk,
	output logic      o_rise_en
);

	logic [DIV_W-1:0] div_cnt;
	logic [DIV_W-1:0] next_div_cnt;
	logic             next_cfg_clk;
	logic             next_rise_en;
	logic [DIV_W-1:0] half;

	// ----------------------------------------------------------------
	// Divider next state
	// ----------------------------------------------------------------
	always_comb
	begin
		half         = i_fast ? FAST_HALF : SLOW_HALF;
		next_div_cnt = div_cnt;
		next_cfg_clk = o_cfg_clk;
		next_rise_en = 1'b0;
		if (!i_run)
		begin
			next_div_cnt = '0;
			next_cfg_clk = 1'b0;
		end
		else if (div_cnt >= half)
		begin
			next_div_cnt = '0;
			next_cfg_clk = ~o_cfg_clk;
			next_rise_en = ~o_cfg_clk;
		end
		else
		begin
			next_div_cnt = div_cnt + DIV_W'(1);
		end
	end

	// Divider registers
	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			div_cnt   <= '0;
			o_cfg_clk <= 1'b0;
			o_rise_en <= 1'b0;
		end
		else
		begin
			div_cnt   <= next_div_cnt;
			o_cfg_clk <= next_cfg_clk;
			o_rise_en <= next_rise_en;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	int unsigned per_cnt;
	int unsigned slow_cnt;
	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
			per_cnt <= 0;
		else if (o_rise_en || !i_run)
			per_cnt <= 0;
		else
			per_cnt <= per_cnt + 1;
	end

	// Cycles run at the slow rate; a rate change mid-period is not judged
	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
			slow_cnt <= 0;
		else if (!i_run || i_fast)
			slow_cnt <= 0;
		else if (slow_cnt < 2 * SLOW_DIV_CYC)
			slow_cnt <= slow_cnt + 1;
	end

	slow_period_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(o_rise_en && slow_cnt >= 2 * SLOW_DIV_CYC) |-> per_cnt + 1 >= SLOW_DIV_CYC
			&& per_cnt + 1 <= SLOW_PERIOD_MAX_NS * 1000 / CLK_PERIOD_PS)
		else $error("slow config clock period out of range");

endmodule
`default_nettype wire

// ### cfg_host.sv
/*
 Host model: writes configuration bytes with selects and a write strobe.
 Assumes the loader's ready flag on i_ready and the shared system clock.
*/
`timescale 1ns/10ps
`default_nettype none
module cfg_host
	import cfg_loader_pkg::*;
(
	input  wire logic         i_clk_sys,
	input  wire logic         i_ready,
	output logic              o_chip_select_low_n,
	output logic              o_chip_select_high,
	output logic              o_write_strobe_n,
	output logic              o_read_strobe_n,
	output logic [BYTE_W-1:0] o_data
);
	// ----------------------------------------------------------------
	// Idle levels
	// ----------------------------------------------------------------
	initial
	begin
		o_chip_select_low_n = 1'b1;
		o_chip_select_high  = 1'b0;
		o_write_strobe_n    = 1'b1;
		o_read_strobe_n     = 1'b1;
		o_data              = 8'h00;
	end

	// One write; wait_rdy low makes a refused strobe during busy
	task automatic write_byte(input logic [BYTE_W-1:0] b, input int hold, input bit wait_rdy);
		int n;
		n = 0;
		@(posedge i_clk_sys);
		// Start as soon as ready is seen, no extra wait
		while (wait_rdy && i_ready !== 1'b1 && n < 5000)
		begin
			@(posedge i_clk_sys);
			n++;
		end
		o_chip_select_low_n <= 1'b0;
		o_chip_select_high  <= 1'b1;
		o_write_strobe_n    <= 1'b0;
		o_data              <= b;
		// Strobe held past one full config period of ready high
		repeat (hold) @(posedge i_clk_sys);
		o_chip_select_low_n <= 1'b1;
		o_chip_select_high  <= 1'b0;
		o_write_strobe_n    <= 1'b1;
		o_data              <= ~b; // Data dropped right at strobe end
	endtask
endmodule
`default_nettype wire

// ### tb_async_peripheral_config_loader.sv
/*
 Testbench for the configuration loader: host model, three clock modes, stall checks.
 Assumes the host model file and the loader package are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_async_peripheral_config_loader;
	import cfg_loader_pkg::*;
	logic clk, rstn, cs_l_n, cs_h, ws_n, rs_n, init_all, master, fast, ext_run;
	logic ext_clk = 1'b0;
	logic ready, config_clock, cbit, cvalid, config_clock_q, ready_q, busy;
	logic [BYTE_W-1:0] data, b;
	int seed, fails, samples_checked, cyc, rises, per, last_rise, stall, n, hold;
	int ext_cnt = 0;
	logic exp_q[$];
	int stalls_q[$];
	localparam int PER_TAB [3] = '{FAST_DIV_CYC, SLOW_DIV_CYC, 30};

	cfg_loader u_dut (.i_clk_sys(clk), .i_rstn(rstn), .i_chip_select_low_n(cs_l_n),
		.i_chip_select_high(cs_h), .i_write_strobe_n(ws_n), .i_read_strobe_n(rs_n),
		.i_data(data), .i_init_all(init_all), .i_master_mode(master), .i_fast_rate(fast),
		.i_ext_config_clock(ext_clk), .o_ready(ready), .o_config_clock(config_clock),
		.o_cfg_bit(cbit), .o_cfg_bit_valid(cvalid));
	cfg_host u_host (.i_clk_sys(clk), .i_ready(ready), .o_chip_select_low_n(cs_l_n),
		.o_chip_select_high(cs_h), .o_write_strobe_n(ws_n), .o_read_strobe_n(rs_n),
		.o_data(data));

	// ----------------------------------------------------------------
	// Clock, external config clock, monitor
	// ----------------------------------------------------------------
	initial clk = 1'b0;
	always #2.5 clk = ~clk;

	// External clock of 150 ns, 15 cycles per half
	always @(posedge clk)
	begin
		ext_cnt <= (ext_run && ext_cnt < 14) ? ext_cnt + 1 : 0;
		if (ext_run && ext_cnt == 14)
			ext_clk <= ~ext_clk;
	end

	// Timeout, config clock period, stall length, serial bits
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 60000)
		begin
			fails++;
			summarize();
		end
		if (config_clock === 1'b1 && config_clock_q === 1'b0)
		begin
			rises++;
			per = cyc - last_rise;
			last_rise = cyc;
			if (busy)
				stall++;
		end
		if (ready === 1'b0 && ready_q === 1'b1)
		begin
			busy = 1'b1;
			stall = 0;
		end
		if (ready === 1'b1 && ready_q === 1'b0 && busy)
		begin
			busy = 1'b0;
			stalls_q.push_back(stall);
		end
		if (cvalid === 1'b1)
		begin
			if (exp_q.size() == 0)
				check_bit(1'b1, 1'b0);
			else
				check_bit(cbit, exp_q.pop_front());
		end
		config_clock_q = config_clock;
		ready_q = ready;
	end

	// ----------------------------------------------------------------
	// Compare tasks and write helper
	// ----------------------------------------------------------------
	task automatic check_bit(input logic got, input logic exp);
		samples_checked++;
		if (got !== exp)
		begin
			fails++;
			$display("[FAIL] %0t serial bit got %b exp %b", $time, got, exp);
		end
	endtask

	task automatic check_range(input int got, input int lo, input int hi);
		samples_checked++;
		if (got < lo || got > hi)
		begin
			fails++;
			$display("[FAIL] %0t value %0d outside %0d..%0d", $time, got, lo, hi);
		end
	endtask

	// Queue expected bits MSB first, write, then time the busy flag
	task automatic do_write(input logic [BYTE_W-1:0] v);
		for (int i = BYTE_W - 1; i >= 0; i--)
			exp_q.push_back(v[i]);
		u_host.write_byte(v, hold, 1'b1);
		n = 0;
		while (ready !== 1'b0 && n <= BUSY_DELAY_CYC)
		begin
			@(posedge clk);
			n++;
		end
		check_range(n, 0, BUSY_DELAY_CYC);
	endtask

	task automatic summarize();
		$display("checked %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		seed = 32'h5AA146A6;
		{fails, samples_checked, cyc, rises, per, last_rise, stall} = '0;
		{rstn, init_all, ext_run, config_clock_q, ready_q, busy} = '0;
		master = 1'b1;
		fast = 1'b1;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		// Nothing moves while the chained init signals are low
		repeat (300) @(posedge clk);
		check_range(rises, 0, 0);
		init_all <= 1'b1;
		for (int m = 0; m < 3; m++)
		begin
			hold = PER_TAB[m] + 4;
			if (m == 1)
				fast <= 1'b0;
			if (m == 2)
			begin
				master <= 1'b0;
				// Quiet external clock for over 4 us before its first edge
				repeat (810) @(posedge clk);
				ext_run <= 1'b1;
			end
			repeat (3 * PER_TAB[m]) @(posedge clk);
			if (m == 0)
				check_range(per * 5, 80, 250);
			if (m == 1)
				check_range(per * 5, 640, 2000);
			if (m == 2)
				check_range(per * 5, 100, 2000);
			stalls_q.delete();
			// Empty converter, then back-to-back bytes, corners first in the fast mode
			for (int k = 0; k < 3; k++)
			begin
				b = 8'($random(seed));
				if (m == 0 && k < 2)
					b = k ? 8'h01 : 8'h80;
				do_write(b);
			end
			// Strobe during busy is refused and adds no bits
			u_host.write_byte(8'hA5, 2, 1'b0);
			// Random idle gap shifts the clock phase of the next write
			repeat ($unsigned($random(seed)) % (PER_TAB[m] * 2)) @(posedge clk);
			do_write(8'($random(seed)));
			n = 0;
			while ((exp_q.size() > 0 || ready !== 1'b1) && n < 20000)
			begin
				@(posedge clk);
				n++;
			end
			check_range(exp_q.size() + stalls_q.size(), 4, 4);
			foreach (stalls_q[i])
				check_range(stalls_q[i], 2, 10);
			check_range(stalls_q[0], 2, 3);
			check_range(stalls_q[2], 7, 10);
		end
		summarize();
	end
endmodule
`default_nettype wire
